// ==== rtl/adb_conv_buf.v ====
// One ADC result register plus its one-word DMA buffer
`timescale 1ns/1ps
module adb_conv_buf #(
  parameter DATA_W = 16
) (
  input  wire              clock,
  input  wire              rst_n,
  input  wire              flush,
  input  wire              accept,
  input  wire              conv_done,
  input  wire [DATA_W-1:0] conv_data,
  input  wire              drain,
  output reg  [DATA_W-1:0] buf_data,
  output reg               buf_full,
  output reg               warn_pulse,
  output reg               err_pulse
);

  reg [DATA_W-1:0] result_reg;
  reg              pending_reg;
  wire             take;

  assign take = accept & conv_done;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      result_reg  <= {DATA_W{1'b0}};
      pending_reg <= 1'b0;
      buf_data    <= {DATA_W{1'b0}};
      buf_full    <= 1'b0;
      warn_pulse  <= 1'b0;
      err_pulse   <= 1'b0;
    end else begin
      warn_pulse <= 1'b0;
      err_pulse  <= 1'b0;
      if (flush) begin
        pending_reg <= 1'b0;
        buf_full    <= 1'b0;
      end else if (take) begin
        result_reg <= conv_data;
        if (!buf_full || (drain && !pending_reg)) begin
          // Buffer free: result moves straight on
          buf_data <= conv_data;
          buf_full <= 1'b1;
        end else if (drain) begin
          // Old word leaves, held result moves up, new one waits
          buf_data   <= result_reg;
          warn_pulse <= 1'b1;
        end else begin
          // Buffer still occupied: hold in result register
          pending_reg <= 1'b1;
          warn_pulse  <= 1'b1;
          err_pulse   <= pending_reg;
        end
      end else if (drain) begin
        if (pending_reg) begin
          buf_data    <= result_reg;
          pending_reg <= 1'b0;
        end else begin
          buf_full <= 1'b0;
        end
      end
    end
  end

endmodule

// ==== rtl/adb_defs.vh ====
// Constants for the ADC DMA buffer and control/status register block
`ifndef ADB_DEFS_VH
`define ADB_DEFS_VH

// Control/status register location and reset value
`define ADB_CS_ADDR        8'hd8
`define ADB_CS_RESET       8'h00

// Control/status register bit positions
`define ADB_BIT_ENABLE     7
`define ADB_BIT_COMPLETE   6
`define ADB_BIT_MODE       5
`define ADB_BIT_ERR1       4
`define ADB_BIT_ERR0       3
`define ADB_BIT_WARN_EN    2
`define ADB_BIT_WARN1      1
`define ADB_BIT_WARN0      0

// Engine states
`define ADB_ST_IDLE        2'h0
`define ADB_ST_RUN         2'h1
`define ADB_ST_DRAIN       2'h2

// Default widths and pointer step
`define ADB_DATA_W         16
`define ADB_ADDR_W         16
`define ADB_ADDR_STEP      2

`endif

// ==== rtl/adb_top.v ====
// ADC-to-memory DMA data path with its control/status register
`timescale 1ns/1ps
`include "adb_defs.vh"
module adb_top #(
  parameter DATA_W    = `ADB_DATA_W,
  parameter ADDR_W    = `ADB_ADDR_W,
  parameter ADDR_STEP = `ADB_ADDR_STEP
) (
  input  wire              clock,
  input  wire              rst_n,
  input  wire [7:0]        sfr_addr,
  input  wire              sfr_wr,
  input  wire              sfr_rd,
  input  wire [7:0]        sfr_wdata,
  output reg  [7:0]        sfr_rdata,
  input  wire              conv0_done,
  input  wire [DATA_W-1:0] conv0_data,
  input  wire              conv1_done,
  input  wire [DATA_W-1:0] conv1_data,
  input  wire              ops_done,
  input  wire [ADDR_W-1:0] start_addr,
  input  wire              offchip_sel,
  input  wire              offchip_access_halt,
  output wire              mem_req,
  output wire [ADDR_W-1:0] mem_addr,
  output wire [DATA_W-1:0] mem_wdata,
  input  wire              mem_grant,
  output wire              offchip_busy,
  output wire              exec_mode_select,
  output wire              engine_enable_busy,
  output wire              dma_irq
);

  //////////////////////////////////////////////////////////////////////////////
  // Declarations

  reg  [1:0]        state_reg;
  reg  [1:0]        state_next;
  reg  [ADDR_W-1:0] ptr_reg;
  reg               complete_reg;
  reg               mode_reg;
  reg               err1_reg;
  reg               err0_reg;
  reg               warn_en_reg;
  reg               warn1_reg;
  reg               warn0_reg;

  wire              cs_write;
  wire              cs_read;
  wire              busy;
  wire              start_cmd;
  wire              stop_cmd;
  wire              flush;
  wire [DATA_W-1:0] buf0_data;
  wire [DATA_W-1:0] buf1_data;
  wire              buf0_full;
  wire              buf1_full;
  wire              warn0_pulse;
  wire              warn1_pulse;
  wire              err0_pulse;
  wire              err1_pulse;
  wire              write_allowed;
  wire              pick0;
  wire              drain0;
  wire              drain1;
  wire              mem_done;
  wire              finish_evt;
  wire [7:0]        cs_value;
  wire              conv_any;
  wire              clr_complete;
  wire              clr_err1;
  wire              clr_err0;
  wire              clr_warn1;
  wire              clr_warn0;
  wire              irq_done;
  wire              irq_err;
  wire              irq_warn;

  // Register image after reset, taken bit by bit
  localparam [7:0]  CS_RESET = `ADB_CS_RESET;

  //////////////////////////////////////////////////////////////////////////////
  // Register access decode

  assign cs_write  = sfr_wr & (sfr_addr == `ADB_CS_ADDR);
  assign cs_read   = sfr_rd & (sfr_addr == `ADB_CS_ADDR);
  assign busy      = (state_reg != `ADB_ST_IDLE);
  assign start_cmd = cs_write & sfr_wdata[`ADB_BIT_ENABLE] & ~busy;
  assign stop_cmd  = cs_write & ~sfr_wdata[`ADB_BIT_ENABLE];
  assign flush     = start_cmd;

  // Writing zero to a flag bit clears it; writing one leaves it alone
  assign clr_complete = cs_write & ~sfr_wdata[`ADB_BIT_COMPLETE];
  assign clr_err1     = cs_write & ~sfr_wdata[`ADB_BIT_ERR1];
  assign clr_err0     = cs_write & ~sfr_wdata[`ADB_BIT_ERR0];
  assign clr_warn1    = cs_write & ~sfr_wdata[`ADB_BIT_WARN1];
  assign clr_warn0    = cs_write & ~sfr_wdata[`ADB_BIT_WARN0];

  //////////////////////////////////////////////////////////////////////////////
  // Per-ADC buffers

  adb_conv_buf #(
    .DATA_W (DATA_W)
  ) u_buf0 (
    .clock      (clock),
    .rst_n      (rst_n),
    .flush      (flush),
    .accept     (busy),
    .conv_done  (conv0_done),
    .conv_data  (conv0_data),
    .drain      (drain0),
    .buf_data   (buf0_data),
    .buf_full   (buf0_full),
    .warn_pulse (warn0_pulse),
    .err_pulse  (err0_pulse)
  );

  adb_conv_buf #(
    .DATA_W (DATA_W)
  ) u_buf1 (
    .clock      (clock),
    .rst_n      (rst_n),
    .flush      (flush),
    .accept     (busy),
    .conv_done  (conv1_done),
    .conv_data  (conv1_data),
    .drain      (drain1),
    .buf_data   (buf1_data),
    .buf_full   (buf1_full),
    .warn_pulse (warn1_pulse),
    .err_pulse  (err1_pulse)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Memory write port

  // Off-chip writes stall while the core owns the external bus
  assign write_allowed = ~(offchip_sel & offchip_access_halt);
  // ADC0 goes first when both buffers hold data
  assign pick0     = buf0_full;
  assign mem_req   = busy & write_allowed & (buf0_full | buf1_full);
  assign mem_wdata = pick0 ? buf0_data : buf1_data;
  assign mem_addr  = ptr_reg;
  assign mem_done  = mem_req & mem_grant;
  assign drain0    = mem_done & pick0;
  assign drain1    = mem_done & ~pick0;
  assign offchip_busy = mem_req & offchip_sel;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ptr_reg <= {ADDR_W{1'b0}};
    end else if (start_cmd) begin
      ptr_reg <= start_addr;
    end else if (mem_done) begin
      ptr_reg <= ptr_reg + ADDR_STEP[ADDR_W-1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Engine state

  // Finishing waits until both buffers have reached memory
  always @* begin
    state_next = state_reg;
    case (state_reg)
      `ADB_ST_IDLE: begin
        if (start_cmd) begin
          state_next = `ADB_ST_RUN;
        end
      end
      `ADB_ST_RUN: begin
        if (stop_cmd) begin
          state_next = `ADB_ST_IDLE;
        end else if (ops_done) begin
          state_next = `ADB_ST_DRAIN;
        end
      end
      `ADB_ST_DRAIN: begin
        if (stop_cmd) begin
          state_next = `ADB_ST_IDLE;
        end else if (!buf0_full && !buf1_full && !conv_any) begin
          state_next = `ADB_ST_IDLE;
        end
      end
      default: begin
        state_next = `ADB_ST_IDLE;
      end
    endcase
  end

  // A result landing in the last cycle would be stranded once idle
  assign conv_any   = conv0_done | conv1_done;
  assign finish_evt = (state_reg == `ADB_ST_DRAIN) & ~stop_cmd & ~conv_any &
                      ~buf0_full & ~buf1_full;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= `ADB_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control and sticky flags

  // Mode and warning enable follow every write, running or not
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg    <= CS_RESET[`ADB_BIT_MODE];
      warn_en_reg <= CS_RESET[`ADB_BIT_WARN_EN];
    end else if (cs_write) begin
      mode_reg    <= sfr_wdata[`ADB_BIT_MODE];
      warn_en_reg <= sfr_wdata[`ADB_BIT_WARN_EN];
    end
  end

  // A hardware set in the same cycle as a clear wins
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      complete_reg <= CS_RESET[`ADB_BIT_COMPLETE];
      err1_reg     <= CS_RESET[`ADB_BIT_ERR1];
      err0_reg     <= CS_RESET[`ADB_BIT_ERR0];
      warn1_reg    <= CS_RESET[`ADB_BIT_WARN1];
      warn0_reg    <= CS_RESET[`ADB_BIT_WARN0];
    end else begin
      if (finish_evt) begin
        complete_reg <= 1'b1;
      end else if (clr_complete) begin
        complete_reg <= 1'b0;
      end
      if (err1_pulse) begin
        err1_reg <= 1'b1;
      end else if (clr_err1) begin
        err1_reg <= 1'b0;
      end
      if (err0_pulse) begin
        err0_reg <= 1'b1;
      end else if (clr_err0) begin
        err0_reg <= 1'b0;
      end
      if (warn1_pulse) begin
        warn1_reg <= 1'b1;
      end else if (clr_warn1) begin
        warn1_reg <= 1'b0;
      end
      if (warn0_pulse) begin
        warn0_reg <= 1'b1;
      end else if (clr_warn0) begin
        warn0_reg <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read-back and outputs

  assign cs_value = {busy, complete_reg, mode_reg, err1_reg, err0_reg,
                     warn_en_reg, warn1_reg, warn0_reg};

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata <= 8'h00;
    end else if (cs_read) begin
      sfr_rdata <= cs_value;
    end else begin
      sfr_rdata <= 8'h00;
    end
  end

  assign exec_mode_select   = mode_reg;
  assign engine_enable_busy = busy;

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt request

  assign irq_done = complete_reg;
  assign irq_err  = err1_reg | err0_reg;
  // Warnings reach the request line only while enabled
  assign irq_warn = warn_en_reg & (warn1_reg | warn0_reg);
  assign dma_irq  = irq_done | irq_err | irq_warn;

endmodule

// ==== test/adb_mem_model.sv ====
// Data memory model that takes DMA writes, with a stall control
`timescale 1ns/1ps
module adb_mem_model (
  input  wire        clock,
  input  wire        rst_n,
  input  wire        mem_req,
  input  wire [15:0] mem_addr,
  input  wire [15:0] mem_wdata,
  input  wire        stall,
  output wire        mem_grant,
  output reg  [3:0]  n_wr
);
  reg [15:0] addr_log [0:15];
  reg [15:0] data_log [0:15];
  // A slow memory holds the grant off while stalled
  assign mem_grant = mem_req & ~stall;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      n_wr <= 4'h0;
    end else if (mem_grant) begin
      addr_log[n_wr] <= mem_addr;
      data_log[n_wr] <= mem_wdata;
      n_wr <= n_wr + 4'h1;
    end
  end
endmodule

// ==== test/adb_top_sva.sv ====
// Port-level assertions for the ADC DMA buffer block
`timescale 1ns/1ps
module adb_top_sva #(
  parameter DATA_W    = 16,
  parameter ADDR_W    = 16,
  parameter ADDR_STEP = 2
) (
  input wire              clock,
  input wire              rst_n,
  input wire [7:0]        sfr_addr,
  input wire              sfr_wr,
  input wire              sfr_rd,
  input wire [7:0]        sfr_wdata,
  input wire [7:0]        sfr_rdata,
  input wire              conv0_done,
  input wire [DATA_W-1:0] conv0_data,
  input wire [ADDR_W-1:0] start_addr,
  input wire              offchip_sel,
  input wire              offchip_access_halt,
  input wire              mem_req,
  input wire [ADDR_W-1:0] mem_addr,
  input wire [DATA_W-1:0] mem_wdata,
  input wire              mem_grant,
  input wire              offchip_busy,
  input wire              exec_mode_select,
  input wire              engine_enable_busy,
  input wire              dma_irq
);
  wire wr_cs = sfr_wr && sfr_addr == 8'hd8;
  wire rd_cs = sfr_rd && sfr_addr == 8'hd8;
  wire hold  = offchip_sel && offchip_access_halt;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence rd_s;
    rd_cs && !sfr_wr;
  endsequence
  sequence start_s;
    wr_cs && sfr_wdata[7] && !engine_enable_busy;
  endsequence
  halt_no_req_a: assert property (hold |-> !mem_req)
    else $error("request while off-chip access halted");
  offchip_flag_a: assert property (
    offchip_busy == (mem_req && offchip_sel))
    else $error("off-chip busy flag wrong");
  fill_at_once_a: assert property (engine_enable_busy && conv0_done
    && !mem_req && !offchip_sel && !wr_cs
    |=> mem_req && mem_wdata == $past(conv0_data))
    else $error("result not moved into empty buffer");
  hold_till_grant_a: assert property (
    mem_req && !mem_grant && !offchip_sel && !conv0_done && !wr_cs
    |=> mem_req && $stable(mem_addr) && $stable(mem_wdata))
    else $error("pending write changed before grant");
  ptr_step_a: assert property (mem_req && mem_grant && !wr_cs
    |=> mem_addr == ADDR_W'($past(mem_addr) + ADDR_STEP))
    else $error("pointer did not advance by one step");
  start_load_a: assert property (start_s
    |=> engine_enable_busy && mem_addr == $past(start_addr))
    else $error("start did not load pointer or set busy");
  stop_idle_a: assert property (
    wr_cs && !sfr_wdata[7] |=> !engine_enable_busy)
    else $error("stop did not clear busy");
  mode_write_a: assert property (wr_cs
    |=> exec_mode_select == $past(sfr_wdata[5]))
    else $error("mode bit not written");
  rd_state_a: assert property (rd_s
    |=> sfr_rdata[7] == $past(engine_enable_busy)
    && sfr_rdata[5] == $past(exec_mode_select))
    else $error("read busy or mode bit wrong");
  irq_flags_a: assert property (rd_s
    |=> $past(dma_irq) == (sfr_rdata[6] | sfr_rdata[4] | sfr_rdata[3]
    | (sfr_rdata[2] & |sfr_rdata[1:0])))
    else $error("interrupt request disagrees with flags");
  rd_idle_zero_a: assert property (!rd_cs |=> sfr_rdata == 8'h00)
    else $error("read data not zero outside a read");
endmodule
bind adb_top adb_top_sva #(
  .DATA_W    (DATA_W),
  .ADDR_W    (ADDR_W),
  .ADDR_STEP (ADDR_STEP)
) u_sva (
  .clock               (clock),
  .rst_n               (rst_n),
  .sfr_addr            (sfr_addr),
  .sfr_wr              (sfr_wr),
  .sfr_rd              (sfr_rd),
  .sfr_wdata           (sfr_wdata),
  .sfr_rdata           (sfr_rdata),
  .conv0_done          (conv0_done),
  .conv0_data          (conv0_data),
  .start_addr          (start_addr),
  .offchip_sel         (offchip_sel),
  .offchip_access_halt (offchip_access_halt),
  .mem_req             (mem_req),
  .mem_addr            (mem_addr),
  .mem_wdata           (mem_wdata),
  .mem_grant           (mem_grant),
  .offchip_busy        (offchip_busy),
  .exec_mode_select    (exec_mode_select),
  .engine_enable_busy  (engine_enable_busy),
  .dma_irq             (dma_irq)
);

// ==== test/testbench.sv ====
// Self-checking testbench for the ADC DMA buffer block
`timescale 1ns/1ps
module testbench;
  reg         clock = 0, rst_n = 0, sfr_wr = 0, sfr_rd = 0, stall = 0;
  reg  [7:0]  sfr_addr = 8'hd8, sfr_wdata = 8'h00, v;
  reg         conv0_done = 0, conv1_done = 0, ops_done = 0;
  reg  [15:0] conv0_data = 0, conv1_data = 0, start_addr = 16'h0100;
  reg         offchip_sel = 0, offchip_access_halt = 0;
  wire [7:0]  sfr_rdata;
  wire [15:0] mem_addr, mem_wdata;
  wire [3:0]  n_wr;
  wire        mem_req, mem_grant, offchip_busy, dma_irq;
  wire        exec_mode_select, engine_enable_busy;
  integer     n_fail = 0, n_tests = 0, cyc = 0, i;
  adb_top dut (
    .clock               (clock),
    .rst_n               (rst_n),
    .sfr_addr            (sfr_addr),
    .sfr_wr              (sfr_wr),
    .sfr_rd              (sfr_rd),
    .sfr_wdata           (sfr_wdata),
    .sfr_rdata           (sfr_rdata),
    .conv0_done          (conv0_done),
    .conv0_data          (conv0_data),
    .conv1_done          (conv1_done),
    .conv1_data          (conv1_data),
    .ops_done            (ops_done),
    .start_addr          (start_addr),
    .offchip_sel         (offchip_sel),
    .offchip_access_halt (offchip_access_halt),
    .mem_req             (mem_req),
    .mem_addr            (mem_addr),
    .mem_wdata           (mem_wdata),
    .mem_grant           (mem_grant),
    .offchip_busy        (offchip_busy),
    .exec_mode_select    (exec_mode_select),
    .engine_enable_busy  (engine_enable_busy),
    .dma_irq             (dma_irq)
  );
  adb_mem_model mem (
    .clock     (clock),
    .rst_n     (rst_n),
    .mem_req   (mem_req),
    .mem_addr  (mem_addr),
    .mem_wdata (mem_wdata),
    .stall     (stall),
    .mem_grant (mem_grant),
    .n_wr      (n_wr)
  );
  always #25 clock = ~clock;
  ////////////////////////////////////////////////////////////////////
  task summarize;
    begin
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  always @(posedge clock) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      n_fail = n_fail + 1;
      summarize;
    end
  end
  task chk(input string nm, input [15:0] e, input [15:0] s);
    begin
      n_tests = n_tests + 1;
      if (s !== e) begin
        n_fail = n_fail + 1;
        $display("Error %0s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  task wr(input [7:0] d);
    begin
      @(negedge clock);
      sfr_wr = 1;
      sfr_wdata = d;
      @(negedge clock);
      sfr_wr = 0;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(negedge clock);
      sfr_rd = 1;
      sfr_addr = a;
      @(negedge clock);
      sfr_rd = 0;
      sfr_addr = 8'hd8;
      v = sfr_rdata;
    end
  endtask
  task pulse(input b0, input b1, input [15:0] d);
    begin
      @(negedge clock);
      conv0_done = b0;
      conv1_done = b1;
      conv0_data = d;
      conv1_data = d + 16'h0001;
      @(negedge clock);
      conv0_done = 0;
      conv1_done = 0;
      @(negedge clock);
    end
  endtask
  ////////////////////////////////////////////////////////////////////
  task t_move;
    begin
      wr(8'h80);
      chk("busy", 1, engine_enable_busy);
      pulse(1, 1, 16'h1234);
      repeat (3) @(negedge clock);
      chk("writes", 2, n_wr);
      chk("addr0", 16'h0100, mem.addr_log[0]);
      chk("data0", 16'h1234, mem.data_log[0]);
      chk("addr1", 16'h0102, mem.addr_log[1]);
      chk("data1", 16'h1235, mem.data_log[1]);
    end
  endtask
  task t_over;
    begin
      stall = 1;
      pulse(1, 1, 16'ha000);
      pulse(1, 1, 16'hb000);
      repeat (3) @(negedge clock);
      chk("irq masked", 0, dma_irq);
      wr(8'h87);
      chk("irq warn", 1, dma_irq);
      pulse(1, 1, 16'hc000);
      repeat (3) @(negedge clock);
      rd(8'hd8);
      chk("flags", 8'h9f, v);
      chk("warn bits", 2'h3, v[1:0]);
      chk("err bits", 2'h3, v[4:3]);
      rd(8'hd9);
      chk("unmapped", 8'h00, v);
      stall = 0;
      repeat (6) @(negedge clock);
      chk("writes", 6, n_wr);
      chk("first", 16'ha000, mem.data_log[2]);
      chk("set0", 16'hc000, mem.data_log[3]);
      chk("held1", 16'ha001, mem.data_log[4]);
      chk("set1", 16'hc001, mem.data_log[5]);
      chk("addr5", 16'h010a, mem.addr_log[5]);
      wr(8'h80);
      rd(8'hd8);
      chk("cleared", 8'h80, v);
      chk("irq off", 0, dma_irq);
    end
  endtask
  task t_halt;
    begin
      offchip_sel = 1;
      offchip_access_halt = 1;
      pulse(1, 0, 16'hd000);
      repeat (3) @(negedge clock);
      chk("halt req", 0, mem_req);
      offchip_access_halt = 0;
      #1;
      chk("xbusy", 1, offchip_busy);
      repeat (2) @(negedge clock);
      chk("resumed", 16'hd000, mem.data_log[6]);
      offchip_sel = 0;
    end
  endtask
  task t_done;
    begin
      @(negedge clock);
      ops_done = 1;
      @(negedge clock);
      ops_done = 0;
      for (i = 0; i < 20 && engine_enable_busy !== 0; i = i + 1)
        @(negedge clock);
      rd(8'hd8);
      chk("complete", 8'h40, v);
      chk("irq done", 1, dma_irq);
      wr(8'ha0);
      chk("mode", 1, exec_mode_select);
      wr(8'h20);
      rd(8'hd8);
      chk("stopped", 8'h20, v);
    end
  endtask
  initial begin
    repeat (8) @(negedge clock);
    rst_n = 1;
    rd(8'hd8);
    chk("reset", 8'h00, v);
    t_move;
    t_over;
    t_halt;
    t_done;
    summarize;
  end
endmodule
